// ### rtl/serdes_channel.sv
// Serializer/deserializer channel with phase aligner, bit slip and FIFOs.
// Assumes one 100 MHz clock; the link clock and serial input are async pins.
`timescale 1ns/100ps

module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_sys,
	input wire logic rst_sync,
	input wire logic clear,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [CW-1:0] count_reg;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		return (p == LAST) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	assign in_ready = (count_reg != FULL);
	assign out_valid = (count_reg != '0);
	assign out_data = mem_reg[rd_ptr_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	// Clear wins over a push or pop in the same cycle
	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else if (clear)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			count_reg <= count_reg + CW'(push) - CW'(pop);
		end
	end
endmodule : stream_fifo

module serdes_channel #(
	parameter int WORD_WIDTH = serdes_channel_pkg::WORD_W,
	parameter int TX_DEPTH = serdes_channel_pkg::TX_FIFO_DEPTH,
	parameter int SYNC_FIFO_DEPTH = serdes_channel_pkg::SYNC_DEPTH
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [3:0] tx_factor,
	input wire logic [WORD_WIDTH-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	output logic tx_load_strobe,
	output logic tx_serial,
	input wire logic tx_clk_lane_mode,
	input wire logic [2:0] tx_fwd_div,
	input wire logic tx_fwd_phase,
	input wire logic tx_bypass,
	input wire logic tx_ddr,
	input wire logic [1:0] tx_bypass_clk_sel,
	input wire logic tick_routing,
	input wire logic tick_side_pll,
	input wire logic tick_edge_pll,
	input wire logic [1:0] tx_bypass_data,
	input wire logic rx_link_clk,
	input wire logic rx_serial,
	input wire logic [3:0] rx_factor,
	input wire logic rx_clk_src,
	input wire logic phase_hold,
	input wire logic rx_fifo_clear,
	input wire logic word_align_slip,
	input wire logic [3:0] slip_rollover,
	output logic slip_rollover_flag,
	output logic phase_locked,
	output logic [2:0] phase_sel,
	output logic [WORD_WIDTH-1:0] rx_word,
	output logic rx_word_valid,
	output logic rx_load_strobe
);
	logic rst_s1_reg;
	logic rst_sync;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s1_reg <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_s1_reg <= 1'b1;
			rst_sync <= rst_s1_reg;
		end
	end

	// Out-of-range settings are clamped rather than refused
	function automatic logic [3:0] clamp_factor(input logic [3:0] f);
		if (f < serdes_channel_pkg::FACTOR_MIN)
			return serdes_channel_pkg::FACTOR_MIN;
		else if (f > serdes_channel_pkg::FACTOR_MAX)
			return serdes_channel_pkg::FACTOR_MAX;
		return f;
	endfunction : clamp_factor

	function automatic logic [4:0] fwd_period(input logic [2:0] code);
		case (code)
			serdes_channel_pkg::FWD_DIV2: return serdes_channel_pkg::FWD_PER2;
			serdes_channel_pkg::FWD_DIV4: return serdes_channel_pkg::FWD_PER4;
			serdes_channel_pkg::FWD_DIV8: return serdes_channel_pkg::FWD_PER8;
			serdes_channel_pkg::FWD_DIV10: return serdes_channel_pkg::FWD_PER10;
			default: return serdes_channel_pkg::FWD_PER1;
		endcase
	endfunction : fwd_period

	// Transmit side: clk_sys stands for the serial-rate clock
	logic [3:0] tx_factor_c;
	logic [3:0] tx_cnt_reg;
	logic [WORD_WIDTH-1:0] tx_shift_reg;
	logic [WORD_WIDTH-1:0] tx_fifo_data;
	logic tx_fifo_valid;
	logic tx_pop;
	logic [4:0] fwd_cnt_reg;
	logic [4:0] fwd_per;
	logic fwd_level;
	logic io_reg0;
	logic io_reg1;
	logic io_half_reg;
	logic byp_tick;
	logic io_out;

	assign tx_factor_c = clamp_factor(tx_factor);
	assign tx_load_strobe = (tx_cnt_reg == '0);
	assign tx_pop = tx_load_strobe && tx_fifo_valid && !tx_bypass;

	stream_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(TX_DEPTH)) tx_fifo (
		.clk_sys(clk_sys),
		.rst_sync(rst_sync),
		.clear(1'b0),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(tx_fifo_valid),
		.out_ready(tx_pop),
		.out_data(tx_fifo_data)
	);

	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			tx_cnt_reg <= '0;
		else if (tx_cnt_reg >= tx_factor_c - 4'h1)
			tx_cnt_reg <= '0;
		else
			tx_cnt_reg <= tx_cnt_reg + 4'h1;
	end

	// Word is left-justified so its MSB leaves first; an empty FIFO sends zeros
	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			tx_shift_reg <= '0;
		else if (tx_load_strobe)
			tx_shift_reg <= tx_pop ? tx_fifo_data << (4'(WORD_WIDTH) - tx_factor_c) : '0;
		else
			tx_shift_reg <= tx_shift_reg << 1;
	end

	assign fwd_per = fwd_period(tx_fwd_div);
	assign fwd_level = (fwd_cnt_reg < (fwd_per >> 1)) ^ tx_fwd_phase;

	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			fwd_cnt_reg <= '0;
		else if (fwd_cnt_reg >= fwd_per - 5'h01)
			fwd_cnt_reg <= '0;
		else
			fwd_cnt_reg <= fwd_cnt_reg + 5'h01;
	end

	always_comb
	begin
		case (tx_bypass_clk_sel)
			serdes_channel_pkg::BYP_SRC_SIDE_PLL: byp_tick = tick_side_pll;
			serdes_channel_pkg::BYP_SRC_EDGE_PLL: byp_tick = tick_edge_pll;
			default: byp_tick = tick_routing;
		endcase
	end

	// Two output registers; in DDR they alternate every clk_sys cycle after a tick
	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			io_reg0 <= 1'b0;
			io_reg1 <= 1'b0;
			io_half_reg <= 1'b0;
		end
		else if (byp_tick)
		begin
			io_reg0 <= tx_ddr ? tx_bypass_data[1] : tx_bypass_data[0];
			io_reg1 <= tx_bypass_data[0];
			io_half_reg <= 1'b0;
		end
		else
			io_half_reg <= tx_ddr && !io_half_reg;
	end

	assign io_out = (tx_ddr && io_half_reg) ? io_reg1 : io_reg0;

	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			tx_serial <= 1'b0;
		else if (tx_bypass)
			tx_serial <= io_out;
		else if (tx_clk_lane_mode)
			tx_serial <= fwd_level;
		else
			tx_serial <= tx_shift_reg[WORD_WIDTH-1];
	end

	// Receive side: link clock and data pass two flops before use
	logic lclk_s1_reg;
	logic lclk_s2_reg;
	logic lclk_s3_reg;
	logic din_s1_reg;
	logic din_s2_reg;
	logic din_s3_reg;
	logic [4:0] slot_cnt_reg;
	logic [2:0] slot;
	logic [2:0] sample_phase;
	logic rx_take;
	logic sync_valid;
	logic sync_bit;
	logic [3:0] rx_factor_c;
	logic [3:0] roll_c;
	logic [3:0] rx_bit_cnt_reg;
	logic [WORD_WIDTH-1:0] rx_shift_reg;
	logic [WORD_WIDTH-1:0] rx_shift_next;
	logic slip_d_reg;
	logic slip_rise;
	logic slip_pending_reg;
	logic [3:0] slip_cnt_reg;

	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			{lclk_s1_reg, lclk_s2_reg, lclk_s3_reg} <= 3'h0;
			{din_s1_reg, din_s2_reg, din_s3_reg} <= 3'h0;
		end
		else
		begin
			{lclk_s1_reg, lclk_s2_reg, lclk_s3_reg} <= {rx_link_clk, lclk_s1_reg, lclk_s2_reg};
			{din_s1_reg, din_s2_reg, din_s3_reg} <= {rx_serial, din_s1_reg, din_s2_reg};
		end
	end

	// Cycles since the link clock rose; saturates if the link clock stops
	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			slot_cnt_reg <= serdes_channel_pkg::SLOT_CNT_MAX;
		else if (lclk_s2_reg && !lclk_s3_reg)
			slot_cnt_reg <= '0;
		else if (slot_cnt_reg != serdes_channel_pkg::SLOT_CNT_MAX)
			slot_cnt_reg <= slot_cnt_reg + 5'h01;
	end

	assign slot = 3'(slot_cnt_reg / 5'(serdes_channel_pkg::SLOT_CYC));

	// Sample opposite the last data transition; hold freezes the choice
	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			phase_sel <= serdes_channel_pkg::PHASE_ZERO;
			phase_locked <= 1'b0;
		end
		else if (din_s2_reg != din_s3_reg && slot_cnt_reg != serdes_channel_pkg::SLOT_CNT_MAX)
		begin
			if (!phase_hold)
				phase_sel <= slot + serdes_channel_pkg::PHASE_HALF_TURN;
			phase_locked <= 1'b1;
		end
	end

	assign sample_phase = rx_clk_src ? serdes_channel_pkg::PHASE_ZERO : phase_sel;
	assign rx_take = (slot_cnt_reg == 5'(sample_phase) * 5'(serdes_channel_pkg::SLOT_CYC));

	stream_fifo #(.WIDTH(1), .DEPTH(SYNC_FIFO_DEPTH)) sync_fifo (
		.clk_sys(clk_sys),
		.rst_sync(rst_sync),
		.clear(rx_fifo_clear),
		.in_valid(rx_take),
		.in_ready(),
		.in_data(din_s2_reg),
		.out_valid(sync_valid),
		.out_ready(1'b1),
		.out_data(sync_bit)
	);

	assign rx_factor_c = clamp_factor(rx_factor);
	assign roll_c = (slip_rollover < serdes_channel_pkg::ROLL_MIN) ? serdes_channel_pkg::ROLL_MIN :
		(slip_rollover > serdes_channel_pkg::ROLL_MAX) ? serdes_channel_pkg::ROLL_MAX : slip_rollover;
	assign slip_rise = word_align_slip && !slip_d_reg;
	assign rx_shift_next = {rx_shift_reg[WORD_WIDTH-2:0], sync_bit};
	assign rx_load_strobe = sync_valid && !slip_pending_reg && rx_bit_cnt_reg >= rx_factor_c - 4'h1;
	assign slip_rollover_flag = (slip_cnt_reg == roll_c);

	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			slip_d_reg <= 1'b0;
		else
			slip_d_reg <= word_align_slip;
	end

	// A new slip request wins over consumption in the same cycle
	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			slip_pending_reg <= 1'b0;
		else if (slip_rise)
			slip_pending_reg <= 1'b1;
		else if (sync_valid)
			slip_pending_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
			slip_cnt_reg <= '0;
		else if (slip_rise)
			slip_cnt_reg <= (slip_cnt_reg >= roll_c) ? 4'h0 : slip_cnt_reg + 4'h1;
	end

	// Holding the bit count for one bit moves the word boundary by one
	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			rx_bit_cnt_reg <= '0;
			rx_shift_reg <= '0;
		end
		else if (sync_valid)
		begin
			rx_shift_reg <= rx_shift_next;
			if (slip_pending_reg)
				rx_bit_cnt_reg <= rx_bit_cnt_reg;
			else if (rx_load_strobe)
				rx_bit_cnt_reg <= '0;
			else
				rx_bit_cnt_reg <= rx_bit_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			rx_word <= '0;
			rx_word_valid <= 1'b0;
		end
		else
		begin
			rx_word_valid <= rx_load_strobe;
			if (rx_load_strobe)
				rx_word <= rx_shift_next & ((WORD_WIDTH'(1) << rx_factor_c) - WORD_WIDTH'(1));
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_sync);

	property p_tx_strobe_gap;
		tx_load_strobe |=> !tx_load_strobe [*2];
	endproperty
	a_tx_strobe_gap: assert property (p_tx_strobe_gap) else $error("tx strobe too close");

	property p_tx_msb_first;
		tx_pop |=> tx_shift_reg[WORD_WIDTH-1] == $past(tx_fifo_data[tx_factor_c - 4'h1]);
	endproperty
	a_tx_msb_first: assert property (p_tx_msb_first) else $error("tx msb not first");

	property p_tx_shift_step;
		!tx_load_strobe |=> tx_shift_reg == {$past(tx_shift_reg[WORD_WIDTH-2:0]), 1'b0};
	endproperty
	a_tx_shift_step: assert property (p_tx_shift_step) else $error("tx shift step wrong");

	property p_tx_lane_out;
		!tx_bypass && !tx_clk_lane_mode |=> tx_serial == $past(tx_shift_reg[WORD_WIDTH-1]);
	endproperty
	a_tx_lane_out: assert property (p_tx_lane_out) else $error("tx lane wrong bit");

	property p_rx_word_pulse;
		rx_load_strobe |=> rx_word_valid ##1 !rx_word_valid;
	endproperty
	a_rx_word_pulse: assert property (p_rx_word_pulse) else $error("rx word valid bad");

	property p_slip_holds_count;
		sync_valid && slip_pending_reg |=> $stable(rx_bit_cnt_reg);
	endproperty
	a_slip_holds_count: assert property (p_slip_holds_count) else $error("slip lost");

	property p_phase_hold;
		phase_hold |=> $stable(phase_sel);
	endproperty
	a_phase_hold: assert property (p_phase_hold) else $error("phase moved in hold");

	property p_slip_roll;
		slip_rise && slip_rollover_flag |=> slip_cnt_reg == 4'h0;
	endproperty
	a_slip_roll: assert property (p_slip_roll) else $error("slip count no rollover");

	property p_sync_clear;
		rx_fifo_clear |=> !sync_valid;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync fifo not cleared");
endmodule : serdes_channel

// ### rtl/serdes_channel_pkg.sv
// Constants shared by the serializer/deserializer channel.
// Assumes a 100 MHz system clock and a link clock sampled by that clock.
package serdes_channel_pkg;

	localparam int WORD_W = 10;
	localparam int FACTOR_W = 4;
	localparam logic [3:0] FACTOR_MIN = 4'h3;
	localparam logic [3:0] FACTOR_MAX = 4'ha;

	localparam int TX_FIFO_DEPTH = 32;
	localparam int SYNC_DEPTH = 6;

	localparam int CLK_PERIOD_NS = 10;
	localparam int LINK_PERIOD_NS = 160;
	localparam int LINK_CYC = LINK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PHASES = 8;
	localparam int PHASE_W = 3;
	localparam int SLOT_CYC = LINK_CYC / PHASES;
	localparam int SLOT_CNT_W = 5;
	localparam logic [4:0] SLOT_CNT_MAX = 5'h10;
	localparam logic [2:0] PHASE_HALF_TURN = 3'h4;
	localparam logic [2:0] PHASE_ZERO = 3'h0;

	localparam logic [3:0] ROLL_MIN = 4'h1;
	localparam logic [3:0] ROLL_MAX = 4'hb;

	// Forwarded clock divisor codes, period in serial bits
	localparam logic [2:0] FWD_DIV1 = 3'h0;
	localparam logic [2:0] FWD_DIV2 = 3'h1;
	localparam logic [2:0] FWD_DIV4 = 3'h2;
	localparam logic [2:0] FWD_DIV8 = 3'h3;
	localparam logic [2:0] FWD_DIV10 = 3'h4;
	localparam logic [4:0] FWD_PER1 = 5'h02;
	localparam logic [4:0] FWD_PER2 = 5'h04;
	localparam logic [4:0] FWD_PER4 = 5'h08;
	localparam logic [4:0] FWD_PER8 = 5'h10;
	localparam logic [4:0] FWD_PER10 = 5'h14;

	// Bypass output register clock sources
	localparam logic [1:0] BYP_SRC_ROUTING = 2'h0;
	localparam logic [1:0] BYP_SRC_SIDE_PLL = 2'h1;
	localparam logic [1:0] BYP_SRC_EDGE_PLL = 2'h2;

endpackage : serdes_channel_pkg

// ### verif/link_source_model.sv
// Remote source-synchronous transmitter feeding the receive lane.
// Assumes the bench calls stream() once; the clock idles low between frames.
`timescale 1ns/100ps

module link_source_model (
	output logic link_clk,
	output logic link_data
);

	initial
	begin
		link_clk = 1'b0;
		link_data = 1'b0;
	end

	// Forwarded clock runs only inside a frame; data leads its rise by a quarter period
	task automatic stream(input logic [9:0] pat, input int f, input int n);
		for (int w = 0; w < n; w++)
		begin
			for (int b = f - 1; b >= 0; b--)
			begin
				link_data = pat[b];
				#40 link_clk = 1'b1;
				#80 link_clk = 1'b0;
				#40;
			end
		end
		// Released line shows no stale value
		link_data = ~link_data;
	endtask : stream

endmodule : link_source_model

// ### verif/source_sync_serdes_channel_tb_top.sv
// Self-checking bench for the serializer/deserializer channel.
// Assumes serdes_channel and link_source_model are compiled before it.
`timescale 1ns/100ps

module source_sync_serdes_channel_tb_top;

	typedef struct {logic [3:0] f; logic [9:0] d; logic [9:0] e;} tx_row_t;

	logic clk_sys, rstn, tx_valid, tx_ready, tx_load_strobe, tx_serial;
	logic tx_clk_lane_mode, tx_fwd_phase, tx_bypass, tx_ddr;
	logic tick_routing, tick_side_pll, tick_edge_pll, rx_link_clk, rx_serial;
	logic rx_clk_src, phase_hold, rx_fifo_clear, word_align_slip;
	logic slip_rollover_flag, phase_locked, rx_word_valid, rx_load_strobe;
	logic [3:0] tx_factor, rx_factor, slip_rollover;
	logic [9:0] tx_data, rx_word, w1, w2;
	logic [2:0] tx_fwd_div, phase_sel, ps;
	logic [1:0] tx_bypass_clk_sel, tx_bypass_data;
	logic a, b;
	int n_errors, num_checks, cyc, per;
	tx_row_t rows[4] = '{'{4'h3, 10'h3ad, 10'h005}, '{4'h4, 10'h0a9, 10'h009},
		'{4'h7, 10'h15a, 10'h05a}, '{4'ha, 10'h2f1, 10'h2f1}};
	int fwd_per[5] = '{2, 4, 8, 16, 20};

	serdes_channel serdes_channel_inst (.clk_sys(clk_sys), .rstn(rstn),
		.tx_factor(tx_factor), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_load_strobe(tx_load_strobe), .tx_serial(tx_serial),
		.tx_clk_lane_mode(tx_clk_lane_mode), .tx_fwd_div(tx_fwd_div),
		.tx_fwd_phase(tx_fwd_phase), .tx_bypass(tx_bypass), .tx_ddr(tx_ddr),
		.tx_bypass_clk_sel(tx_bypass_clk_sel), .tick_routing(tick_routing),
		.tick_side_pll(tick_side_pll), .tick_edge_pll(tick_edge_pll),
		.tx_bypass_data(tx_bypass_data), .rx_link_clk(rx_link_clk),
		.rx_serial(rx_serial), .rx_factor(rx_factor), .rx_clk_src(rx_clk_src),
		.phase_hold(phase_hold), .rx_fifo_clear(rx_fifo_clear),
		.word_align_slip(word_align_slip), .slip_rollover(slip_rollover),
		.slip_rollover_flag(slip_rollover_flag), .phase_locked(phase_locked),
		.phase_sel(phase_sel), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
		.rx_load_strobe(rx_load_strobe));

	link_source_model link_source_model_inst (.link_clk(rx_link_clk),
		.link_data(rx_serial));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_errors++;
			finish_test();
		end
	end

	task automatic check_val(input string name, input logic [9:0] exp, input logic [9:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check_val

	task automatic check_cnt(input string name, input int exp, input int got);
		num_checks++;
		if (got != exp)
		begin
			n_errors++;
			$display("ERROR %s expected %0d seen %0d", name, exp, got);
		end
	endtask : check_cnt

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// Sampled at falling edges so a rise is never missed or double counted
	task automatic lane_period(output int p);
		logic prev;
		p = 0;
		do @(negedge clk_sys); while (tx_serial !== 1'b0);
		do @(negedge clk_sys); while (tx_serial !== 1'b1);
		do
		begin
			prev = tx_serial;
			@(negedge clk_sys);
			p++;
		end
		while (!(tx_serial === 1'b1 && prev !== 1'b1) && p < 40);
	endtask : lane_period

	task automatic strobe_gap(output int p);
		p = 0;
		do @(negedge clk_sys); while (tx_load_strobe !== 1'b1);
		do
		begin
			@(negedge clk_sys);
			p++;
		end
		while (tx_load_strobe !== 1'b1 && p < 20);
	endtask : strobe_gap

	task automatic pulse_tick(input int i);
		tick_routing = (i == 0);
		tick_side_pll = (i == 1);
		tick_edge_pll = (i == 2);
		@(negedge clk_sys);
		{tick_routing, tick_side_pll, tick_edge_pll} = 3'h0;
		repeat (3) @(negedge clk_sys);
	endtask : pulse_tick

	task automatic next_word(output logic [9:0] w);
		int k;
		k = 0;
		do
		begin
			@(negedge clk_sys);
			k++;
		end
		while (rx_word_valid !== 1'b1 && k < 400);
		// A word that never comes counts as a mismatch
		if (rx_word_valid !== 1'b1)
			n_errors++;
		w = rx_word;
	endtask : next_word

	task automatic slip_once();
		word_align_slip = 1'b1;
		repeat (2) @(negedge clk_sys);
		word_align_slip = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : slip_once

	initial
	begin
		{rstn, tx_valid, tx_clk_lane_mode, tx_fwd_phase, tx_bypass, tx_ddr} = 6'h0;
		{tick_routing, tick_side_pll, tick_edge_pll, rx_clk_src} = 4'h0;
		{phase_hold, rx_fifo_clear, word_align_slip} = 3'h0;
		tx_factor = 4'h4;
		rx_factor = 4'h4;
		slip_rollover = 4'h2;
		tx_data = 10'h000;
		tx_fwd_div = 3'h0;
		tx_bypass_clk_sel = 2'h0;
		tx_bypass_data = 2'h0;
		repeat (20) @(negedge clk_sys);
		check_val("tx_serial_rst", 10'h000, {9'h0, tx_serial});
		check_val("phase_sel_rst", 10'h000, {7'h0, phase_sel});
		check_val("word_valid_rst", 10'h000, {9'h0, rx_word_valid});
		check_val("rx_strobe_rst", 10'h000, {9'h0, rx_load_strobe});
		check_val("tx_ready_rst", 10'h001, {9'h0, tx_ready});
		rstn = 1'b1;
		repeat (4) @(negedge clk_sys);
		// Ordinary cases: one word per factor, MSB first
		foreach (rows[i])
		begin
			tx_factor = rows[i].f;
			strobe_gap(per);
			strobe_gap(per);
			check_cnt("strobe_gap", int'(rows[i].f), per);
			tx_data = rows[i].d;
			tx_valid = 1'b1;
			@(negedge clk_sys);
			tx_valid = 1'b0;
			do @(negedge clk_sys); while (tx_load_strobe !== 1'b1);
			// Pop edge; the MSB stands after the edge that follows it
			@(posedge clk_sys);
			w1 = 10'h000;
			for (int k = 0; k < int'(rows[i].f); k++)
			begin
				@(posedge clk_sys);
				@(negedge clk_sys);
				w1 = {w1[8:0], tx_serial};
			end
			check_val("tx_word", rows[i].e, w1);
		end
		// Forwarded clock on the lane, every divisor code
		tx_clk_lane_mode = 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			tx_fwd_div = 3'(i);
			repeat (4) @(negedge clk_sys);
			lane_period(per);
			check_cnt("fwd_period", fwd_per[i], per);
		end
		a = tx_serial;
		tx_fwd_phase = 1'b1;
		repeat (20) @(negedge clk_sys);
		check_val("fwd_phase", {9'h0, ~a}, {9'h0, tx_serial});
		// Bypass registers, each clock source, wrong tick ignored
		tx_clk_lane_mode = 1'b0;
		tx_bypass = 1'b1;
		tx_bypass_data = 2'h1;
		pulse_tick(0);
		check_val("byp_sdr0", 10'h001, {9'h0, tx_serial});
		for (int s = 1; s < 3; s++)
		begin
			tx_bypass_clk_sel = 2'(s);
			tx_bypass_data = 2'(s - 1);
			pulse_tick((s + 1) % 3);
			check_val("byp_hold", 10'(2 - s), {9'h0, tx_serial});
			pulse_tick(s);
			check_val("byp_sdr", 10'(s - 1), {9'h0, tx_serial});
		end
		tx_ddr = 1'b1;
		tx_bypass_data = 2'h2;
		pulse_tick(2);
		a = tx_serial;
		@(negedge clk_sys);
		b = tx_serial;
		check_val("byp_ddr", 10'h001, {9'h0, a ^ b});
		// Receive path: one-hot stream, lock, clear, hold, slips
		fork
			link_source_model_inst.stream(10'h008, 4, 160);
		join_none
		repeat (6) next_word(w1);
		check_val("locked", 10'h001, {9'h0, phase_locked});
		rx_fifo_clear = 1'b1;
		@(negedge clk_sys);
		rx_fifo_clear = 1'b0;
		phase_hold = 1'b1;
		ps = phase_sel;
		repeat (8) next_word(w1);
		check_val("phase_held", {7'h0, ps}, {7'h0, phase_sel});
		check_cnt("ones", 1, $countones(w1));
		check_val("upper_zero", 10'h000, {w1[9:4], 4'h0});
		slip_once();
		repeat (4) next_word(w2);
		check_val("slip_word", {6'h0, w1[2:0], w1[3]}, w2);
		check_val("roll_flag1", 10'h000, {9'h0, slip_rollover_flag});
		slip_once();
		check_val("roll_flag2", 10'h001, {9'h0, slip_rollover_flag});
		slip_once();
		check_val("roll_flag3", 10'h000, {9'h0, slip_rollover_flag});
		// Fixed sampling phase still yields one-hot words
		rx_clk_src = 1'b1;
		repeat (3) next_word(w1);
		check_cnt("ones_fixed", 1, $countones(w1));
		// Bypass stops pops, so 32 pushes fill the transmit FIFO
		tx_valid = 1'b1;
		repeat (32) @(negedge clk_sys);
		check_val("tx_ready_full", 10'h000, {9'h0, tx_ready});
		tx_valid = 1'b0;
		finish_test();
	end

endmodule : source_sync_serdes_channel_tb_top
